// *** rtl/ash_pkg.sv ***
// shared constants and types for the serial host port link and both of its ends
package ash_pkg;
  // output word layout and minimum write clock count
  localparam int WORD_W = 32;
  localparam int RES_LSB = 18;
  localparam int WRITE_MIN_CLKS = 32;
  // command opcodes in bits 31:27 of a 32-bit input command
  localparam logic [4:0] OP_CLEAR = 5'h18;
  localparam logic [4:0] OP_READ_HW = 5'h19;
  localparam logic [4:0] OP_READ_B = 5'h09;
  localparam logic [4:0] OP_WRITE = 5'h1A;
  localparam logic [4:0] OP_SET = 5'h1B;
  // write sub-codes in bits 26:25
  localparam logic [1:0] WR_HI = 2'h1;
  localparam logic [1:0] WR_LO = 2'h2;
  // device register byte addresses
  localparam logic [7:0] ADDR_ID = 8'h00;
  localparam logic [7:0] ADDR_IN_CTL = 8'h08;
  localparam logic [7:0] ADDR_OUT_CTL = 8'h0C;
  localparam logic [7:0] ADDR_DOUT_CTL = 8'h10;
  // field positions
  localparam int ID_LSB = 16;
  localparam int OUT_MODE_LSB = 0;
  localparam int SECOND_LANE_LSB = 2;
  localparam int STROBE_SRC_BIT = 6;
  localparam logic [1:0] DUAL_LANE_CODE = 2'h3;
  localparam int APP_PARITY_BIT = 0;
  localparam int APP_RANGE_BIT = 1;
  localparam int APP_INALM_BIT = 2;
  localparam int APP_SUPALM_BIT = 3;
  localparam int APP_ID_BIT = 4;
  // writable bits of each device register
  localparam logic [31:0] ID_WMASK = 32'h000F0000;
  localparam logic [31:0] IN_WMASK = 32'h00000003;
  localparam logic [31:0] OUT_WMASK = 32'h0000004F;
  localparam logic [31:0] DOUT_WMASK = 32'h0000001F;
  // device reset values
  localparam logic [1:0] IN_CTL_RST = 2'h0;
  localparam logic [7:0] OUT_CTL_RST = 8'h00;
  localparam logic [7:0] DOUT_CTL_RST = 8'h00;
  localparam logic [3:0] ID_RST = 4'h0;
  // host controller register byte offsets
  localparam logic [7:0] H_CFG = 8'h00;
  localparam logic [7:0] H_CMD = 8'h04;
  localparam logic [7:0] H_RX = 8'h08;
  localparam logic [7:0] H_STAT = 8'h0C;
  // host configuration fields
  localparam int HC_MODE_LSB = 0;
  localparam int HC_DUAL_BIT = 2;
  localparam int HC_SRC_BIT = 3;
  localparam int HC_SRCINT_BIT = 4;
  localparam int HC_NCLK_LSB = 8;
  localparam logic [31:0] HC_CFG_WMASK = 32'h00003F1F;
  localparam logic [31:0] HC_CFG_RST = 32'h00002000;
  // timing counts in hclk cycles
  localparam int SCLK_HALF_DEF = 4;
  localparam int STROBE_HALF_DEF = 4;
  // host frame sequencer states
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN = 2'b01,
    HS_HOLD = 2'b10
  } ash_host_state_t;
endpackage

// *** rtl/ash_link_if.sv ***
// serial link between the converter port and its host controller
`timescale 1ns/10ps
interface ash_link_if;
  logic cs_n; // frame select, low during a frame
  logic sclk; // serial clock from the host
  logic sdi; // serial data into the device
  logic serial_out_lane0; // first output lane
  logic alarm_lane1_output_pin; // alarm level or second output lane
  logic ready_strobe_pin; // ready level or output strobe clock
  modport dev (
    input cs_n, sclk, sdi,
    output serial_out_lane0, alarm_lane1_output_pin, ready_strobe_pin
  );
  modport host (
    output cs_n, sclk, sdi,
    input serial_out_lane0, alarm_lane1_output_pin, ready_strobe_pin
  );
endinterface

// *** rtl/ash_dev_end.sv ***
// converter serial host port: output word packing, config writes, read lanes and strobe
//
// Contract
// RQ1 - all flags: result, id, alarms, range, parity, zeros
// RQ2 - enabled flags packed contiguously below result, zeros after
// RQ3 - four clock modes selected by input mode field
// RQ4 - reset restores idle-low capture-rising mode
// RQ5 - host changes mode in default, then uses new
// RQ6 - selected mode governs reads and writes alike
// RQ7 - host gives at least 32 clocks per write
// RQ8 - msb launch at select fall or first edge
// RQ9 - host sets output mode 00b for legacy reads
// RQ10 - legacy modes keep ready pin low all frame
// RQ11 - short frames read only leading msbs
// RQ12 - long frame, output control zero: daisy chain
// RQ13 - second lane code 11b turns alarm pin into lane
// RQ14 - dual lane: two bits per launch edge
// RQ15 - source-synchronous: strobe pin drives output clock
// RQ16 - strobe source bit picks host or internal clock
// RQ17 - dual lane also in source-synchronous modes
// RQ18 - read command loads register bits next frame
// RQ19 - config write applied at frame-ending select rise
// RQ20 - launch on edge opposite the capture edge
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module ash_dev_end #(
  parameter int STROBE_HALF = ash_pkg::STROBE_HALF_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  ash_link_if.dev link,
  input wire logic [13:0] conv_result,
  input wire logic [1:0] supply_alarm,
  input wire logic [1:0] input_alarm,
  input wire logic [3:0] input_range,
  output logic [1:0] input_clock_mode,
  output logic [1:0] output_transfer_mode
);
  if (STROBE_HALF < 2 || STROBE_HALF > 256) begin : g_chk
    $error("STROBE_HALF must lie in 2..256");
  end

  localparam logic [7:0] HALF_LAST = 8'(STROBE_HALF - 1);
  // field positions, declared before the decode that uses them
  localparam int ID_LSB = ash_pkg::ID_LSB;
  localparam int OUT_MODE_LSB = ash_pkg::OUT_MODE_LSB;
  localparam int SECOND_LANE_LSB = ash_pkg::SECOND_LANE_LSB;
  localparam int STROBE_SRC_BIT = ash_pkg::STROBE_SRC_BIT;

  logic cs_q_ff; // select level of the previous cycle
  logic sclk_q_ff; // serial clock level of the previous cycle
  logic [1:0] in_mode_ff; // input clock mode
  logic [7:0] out_ctl_ff; // output control byte
  logic [7:0] dout_ctl_ff; // append enables
  logic [3:0] node_id_ff; // node id for appended field
  logic [31:0] out_sr_ff; // output shift register, msb on lane 0
  logic [31:0] in_sr_ff; // input command shift register
  logic [5:0] in_cnt_ff; // captured bits, saturating
  logic [31:0] rd_word_ff; // register read word for the next frame
  logic rd_pend_ff; // next frame carries register data
  logic first_ff; // first launch edge still ahead in late modes
  logic din_ff; // last captured input bit, for the daisy chain
  logic strobe_ff; // strobe pin level
  logic alarm_ff; // alarm level for the shared pin
  logic [7:0] div_ff; // internal strobe half-period count
  logic [6:0] edge_ff; // internal strobe edges in this frame

  logic in_frame, cs_fall, cs_rise, sclk_rise, sclk_fall;
  logic cap_rise, cap_edge, launch_edge, dual, src, src_int, daisy;
  logic tick, nxt_strobe, int_fall, shift_edge;
  logic [6:0] edge_lim;
  logic [4:0] op;
  logic [7:0] addr;
  logic [31:0] cur, val, msk, nxt_reg;

  // frame and edge detection on synchronous pins
  assign in_frame = ~link.cs_n;
  assign cs_fall = cs_q_ff & ~link.cs_n;
  assign cs_rise = ~cs_q_ff & link.cs_n;
  assign sclk_rise = in_frame & ~sclk_q_ff & link.sclk;
  assign sclk_fall = in_frame & sclk_q_ff & ~link.sclk;
  // modes 00 and 11 capture on rising edge, 01 and 10 on falling
  assign cap_rise = ~(in_mode_ff[1] ^ in_mode_ff[0]); // [RQ3] [RQ6]
  assign cap_edge = cap_rise ? sclk_rise : sclk_fall;
  assign launch_edge = cap_rise ? sclk_fall : sclk_rise; // [RQ20]
  // output configuration decode
  assign dual = out_ctl_ff[SECOND_LANE_LSB +: 2] == ash_pkg::DUAL_LANE_CODE; // [RQ13] [RQ17]
  assign src = |out_ctl_ff[OUT_MODE_LSB +: 2];
  assign src_int = src & out_ctl_ff[STROBE_SRC_BIT]; // [RQ16]
  assign daisy = out_ctl_ff == 8'h00; // [RQ12]
  // internal strobe pacing: 32 or 16 strobe periods per frame
  assign tick = div_ff == HALF_LAST;
  assign edge_lim = dual ? 7'h20 : 7'h40;
  assign int_fall = src_int & strobe_ff & ~nxt_strobe;
  assign shift_edge = src_int ? int_fall : launch_edge;
  assign input_clock_mode = in_mode_ff;
  assign output_transfer_mode = out_ctl_ff[OUT_MODE_LSB +: 2];

  // conversion word with appended flags in fixed order
  function automatic logic [31:0] pack_word(input logic [7:0] en);
    logic [31:0] w;
    int p;
    w = '0;
    w[31:ash_pkg::RES_LSB] = conv_result; // [RQ1]
    p = ash_pkg::RES_LSB;
    // each enabled field takes the next bits below, disabled ones leave no gap
    if (en[ash_pkg::APP_ID_BIT]) begin
      p = p - 4;
      w[p +: 4] = node_id_ff; // [RQ2]
    end
    if (en[ash_pkg::APP_SUPALM_BIT]) begin
      p = p - 2;
      w[p +: 2] = supply_alarm; // [RQ2]
    end
    if (en[ash_pkg::APP_INALM_BIT]) begin
      p = p - 2;
      w[p +: 2] = input_alarm; // [RQ2]
    end
    if (en[ash_pkg::APP_RANGE_BIT]) begin
      p = p - 4;
      w[p +: 4] = input_range; // [RQ2]
    end
    if (en[ash_pkg::APP_PARITY_BIT]) begin
      p = p - 2;
      // result parity, then parity of the appended flags
      w[p +: 2] = {^conv_result, ^w[17:0]}; // [RQ1]
    end
    return w; // every bit below p stays zero
  endfunction

  // register readback by address
  function automatic logic [31:0] rd32(input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case ({a[7:2], 2'b00})
      ash_pkg::ADDR_ID: r[ID_LSB +: 4] = node_id_ff;
      ash_pkg::ADDR_IN_CTL: r[1:0] = in_mode_ff;
      ash_pkg::ADDR_OUT_CTL: r[7:0] = out_ctl_ff;
      ash_pkg::ADDR_DOUT_CTL: r[7:0] = dout_ctl_ff;
      default: r = '0; // unmapped reads as zero
    endcase
    return r;
  endfunction

  // command field decode and masked register update
  always_comb begin
    op = in_sr_ff[31:27];
    addr = in_sr_ff[23:16];
    cur = rd32(addr);
    val = addr[1] ? {in_sr_ff[15:0], 16'h0000} : {16'h0000, in_sr_ff[15:0]};
    msk = addr[1] ? 32'hFFFF0000 : 32'h0000FFFF;
    // byte-only writes keep the other byte of the half-word
    if (in_sr_ff[26:25] == ash_pkg::WR_HI) begin
      msk = addr[1] ? 32'hFF000000 : 32'h0000FF00;
    end else if (in_sr_ff[26:25] == ash_pkg::WR_LO) begin
      msk = addr[1] ? 32'h00FF0000 : 32'h000000FF;
    end
    if (op == ash_pkg::OP_SET) begin
      nxt_reg = cur | (val & msk);
    end else if (op == ash_pkg::OP_CLEAR) begin
      nxt_reg = cur & ~(val & msk);
    end else begin
      nxt_reg = (cur & ~msk) | (val & msk);
    end
  end

  // strobe level: low in legacy modes, copied or generated clock otherwise
  always_comb begin
    nxt_strobe = 1'b0; // [RQ10]
    if (in_frame && src) begin
      if (src_int) begin
        nxt_strobe = (tick && edge_ff < edge_lim) ? ~strobe_ff : strobe_ff; // [RQ16]
      end else begin
        nxt_strobe = cap_rise ? link.sclk : ~link.sclk; // [RQ15]
      end
    end
  end

  // pin history for edge detection, and the registered alarm level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cs_q_ff <= 1'b1;
      sclk_q_ff <= 1'b0;
      alarm_ff <= 1'b0;
    end else if (ce) begin
      cs_q_ff <= link.cs_n;
      sclk_q_ff <= link.sclk;
      alarm_ff <= |{supply_alarm, input_alarm};
    end
  end

  // configuration registers, updated when the frame ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_mode_ff <= ash_pkg::IN_CTL_RST; // [RQ4]
      out_ctl_ff <= ash_pkg::OUT_CTL_RST;
      dout_ctl_ff <= ash_pkg::DOUT_CTL_RST;
      node_id_ff <= ash_pkg::ID_RST;
    end else if (ce && cs_rise && in_cnt_ff >= 6'(ash_pkg::WRITE_MIN_CLKS)) begin // [RQ7]
      if (op == ash_pkg::OP_WRITE || op == ash_pkg::OP_SET || op == ash_pkg::OP_CLEAR) begin
        case ({addr[7:2], 2'b00})
          ash_pkg::ADDR_ID: node_id_ff <= nxt_reg[ID_LSB +: 4]; // [RQ19]
          ash_pkg::ADDR_IN_CTL: in_mode_ff <= nxt_reg[1:0]; // [RQ19] [RQ5]
          ash_pkg::ADDR_OUT_CTL: out_ctl_ff <= nxt_reg[7:0] & ash_pkg::OUT_WMASK[7:0];
          ash_pkg::ADDR_DOUT_CTL: dout_ctl_ff <= nxt_reg[7:0] & ash_pkg::DOUT_WMASK[7:0];
          default: ; // writes to other addresses have no effect
        endcase
      end
    end
  end

  // read command handling: register data goes out in the following frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_ff <= 1'b0;
      rd_word_ff <= '0;
    end else if (ce && cs_rise) begin
      rd_pend_ff <= 1'b0;
      if (in_cnt_ff >= 6'(ash_pkg::WRITE_MIN_CLKS)) begin
        if (op == ash_pkg::OP_READ_HW) begin
          rd_pend_ff <= 1'b1;
          rd_word_ff <= {addr[1] ? cur[31:16] : cur[15:0], 16'h0000}; // [RQ18]
        end else if (op == ash_pkg::OP_READ_B) begin
          rd_pend_ff <= 1'b1;
          rd_word_ff <= {cur[{addr[1:0], 3'b000} +: 8], 24'h000000}; // [RQ18]
        end
      end
    end
  end

  // input capture on the mode's capture edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_sr_ff <= '0;
      in_cnt_ff <= '0;
      din_ff <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        in_cnt_ff <= '0;
      end else if (cap_edge) begin
        in_sr_ff <= {in_sr_ff[30:0], link.sdi};
        din_ff <= link.sdi;
        if (in_cnt_ff != 6'h3F) begin
          in_cnt_ff <= in_cnt_ff + 6'h01;
        end
      end
    end
  end

  // output shift register: loaded at select fall, shifted on launch edges or on internal strobe falls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_sr_ff <= '0;
      first_ff <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        out_sr_ff <= rd_pend_ff ? rd_word_ff : pack_word(dout_ctl_ff); // [RQ18]
        // without the internal strobe, modes 01 and 11 hold the msb back until the first clock edge
        first_ff <= in_mode_ff[0] & ~src_int; // [RQ8]
      end else if (shift_edge) begin
        if (first_ff) begin
          first_ff <= 1'b0; // [RQ8]
        end else if (dual) begin
          out_sr_ff <= {out_sr_ff[29:0], 2'b00}; // [RQ14] [RQ17]
        end else begin
          // chained upstream data follows our own word; short frames just stop
          out_sr_ff <= {out_sr_ff[30:0], daisy & din_ff}; // [RQ12] [RQ11]
        end
      end
    end
  end

  // strobe pin and internal strobe pacing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_ff <= 1'b0;
      div_ff <= '0;
      edge_ff <= '0;
    end else if (ce) begin
      strobe_ff <= nxt_strobe; // [RQ15]
      if (!in_frame || !src_int) begin
        div_ff <= '0;
        edge_ff <= '0;
      end else if (tick) begin
        div_ff <= '0;
        if (edge_ff < edge_lim) begin
          edge_ff <= edge_ff + 7'h01;
        end
      end else begin
        div_ff <= div_ff + 8'h01;
      end
    end
  end

  // lane pins: lane 1 takes over the alarm pin in dual mode
  assign link.serial_out_lane0 = out_sr_ff[31];
  assign link.alarm_lane1_output_pin = dual ? out_sr_ff[30] : alarm_ff; // [RQ13]
  assign link.ready_strobe_pin = strobe_ff; // [RQ10]
endmodule

// *** rtl/ash_host_end.sv ***
// host controller end: AHB-Lite registers and frame sequencer for the serial link
`timescale 1ns/10ps
module ash_host_end #(
  parameter int SCLK_HALF = ash_pkg::SCLK_HALF_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  ash_link_if.host link
);
  if (SCLK_HALF < 4 || SCLK_HALF > 256) begin : g_chk
    $error("SCLK_HALF must lie in 4..256");
  end

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

  ash_pkg::ash_host_state_t state_ff; // frame sequencer state
  logic [31:0] cfg_ff; // mode, lanes, strobe use, clock count
  logic [31:0] tx_ff; // command being sent, msb first
  logic [31:0] rx_ff; // received bits, right aligned
  logic [31:0] hrdata_ff; // read data for the data phase
  logic wr_ph_ff; // write data phase pending
  logic [7:0] waddr_ff; // write offset
  logic cs_n_ff, sclk_ff, sdi_ff, first_ff, strb_q_ff;
  logic [7:0] hcnt_ff; // half period counter
  logic [6:0] edges_ff; // sclk edges made in this frame
  logic [5:0] rxcnt_ff; // samples taken in this frame

  logic [1:0] mode;
  logic [5:0] nclk;
  logic dual, src, srcint, cap_rise, tick, rising, samp, start, aph;

  assign mode = cfg_ff[ash_pkg::HC_MODE_LSB +: 2];
  assign nclk = cfg_ff[ash_pkg::HC_NCLK_LSB +: 6];
  assign dual = cfg_ff[ash_pkg::HC_DUAL_BIT];
  assign src = cfg_ff[ash_pkg::HC_SRC_BIT];
  assign srcint = src & cfg_ff[ash_pkg::HC_SRCINT_BIT];
  assign cap_rise = ~(mode[1] ^ mode[0]);
  assign tick = hcnt_ff == HALF_LAST;
  assign rising = ~sclk_ff; // the next toggle is a rising edge
  // sample on own capture edge, or on strobe rise in source-synchronous use
  assign samp = src ? (link.ready_strobe_pin & ~strb_q_ff & state_ff != ash_pkg::HS_IDLE)
                    : (state_ff == ash_pkg::HS_RUN && tick && rising == cap_rise);
  assign aph = hsel & hready & htrans[1];
  assign start = wr_ph_ff & waddr_ff == ash_pkg::H_CMD & state_ff == ash_pkg::HS_IDLE;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign link.cs_n = cs_n_ff;
  assign link.sclk = sclk_ff;
  assign link.sdi = sdi_ff;

  // bus address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_ff <= 1'b0;
      waddr_ff <= '0;
      hrdata_ff <= '0;
    end else if (ce) begin
      wr_ph_ff <= aph & hwrite;
      waddr_ff <= {haddr[7:2], 2'b00};
      if (aph && !hwrite) begin
        case ({haddr[7:2], 2'b00})
          ash_pkg::H_CFG: hrdata_ff <= cfg_ff;
          ash_pkg::H_RX: hrdata_ff <= rx_ff;
          ash_pkg::H_STAT: hrdata_ff <= {31'h00000000, state_ff != ash_pkg::HS_IDLE};
          default: hrdata_ff <= '0;
        endcase
      end
    end
  end

  // configuration, held while a frame runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= ash_pkg::HC_CFG_RST;
    end else if (ce && wr_ph_ff && waddr_ff == ash_pkg::H_CFG
                 && state_ff == ash_pkg::HS_IDLE) begin
      // software moves the mode only after the device took it
      cfg_ff <= hwdata & ash_pkg::HC_CFG_WMASK; // [RQ5] [RQ9]
    end
  end

  // frame sequencer: select, clock, data out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ash_pkg::HS_IDLE;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      sdi_ff <= 1'b0;
      tx_ff <= '0;
      first_ff <= 1'b0;
      hcnt_ff <= '0;
      edges_ff <= '0;
    end else if (ce) begin
      unique case (state_ff)
        ash_pkg::HS_IDLE: begin
          sclk_ff <= mode[1]; // idle level shows the mode at select fall [RQ3]
          if (start) begin
            state_ff <= ash_pkg::HS_RUN;
            cs_n_ff <= 1'b0;
            tx_ff <= hwdata;
            sdi_ff <= hwdata[31];
            first_ff <= mode[0];
            hcnt_ff <= '0;
            edges_ff <= '0;
          end
        end
        ash_pkg::HS_RUN: begin
          hcnt_ff <= tick ? 8'h00 : hcnt_ff + 8'h01;
          if (srcint) begin
            if (rxcnt_ff == nclk) begin
              state_ff <= ash_pkg::HS_HOLD;
            end
          end else if (edges_ff == {nclk, 1'b0}) begin
            state_ff <= ash_pkg::HS_HOLD; // short or long frames by clock count [RQ11] [RQ7]
          end else if (tick) begin
            sclk_ff <= ~sclk_ff;
            edges_ff <= edges_ff + 7'h01;
            if (rising != cap_rise) begin
              if (first_ff) begin
                first_ff <= 1'b0;
              end else begin
                tx_ff <= {tx_ff[30:0], 1'b0};
                sdi_ff <= tx_ff[30];
              end
            end
          end
        end
        ash_pkg::HS_HOLD: begin
          // let the last strobe arrive before the frame ends
          hcnt_ff <= tick ? 8'h00 : hcnt_ff + 8'h01;
          if (tick) begin
            cs_n_ff <= 1'b1;
            state_ff <= ash_pkg::HS_IDLE;
          end
        end
        default: state_ff <= ash_pkg::HS_IDLE;
      endcase
    end
  end

  // receive shift register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ff <= '0;
      rxcnt_ff <= '0;
      strb_q_ff <= 1'b0;
    end else if (ce) begin
      strb_q_ff <= link.ready_strobe_pin;
      if (start) begin
        rx_ff <= '0;
        rxcnt_ff <= '0;
      end else if (samp) begin
        rxcnt_ff <= rxcnt_ff + 6'h01;
        if (dual) begin
          rx_ff <= {rx_ff[29:0], link.serial_out_lane0, link.alarm_lane1_output_pin};
        end else begin
          rx_ff <= {rx_ff[30:0], link.serial_out_lane0};
        end
      end
    end
  end
endmodule

// *** verif/ash_chk.sv ***
// link checker: timing relations on the serial wires between both ends
`timescale 1ns/10ps
module ash_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_out_lane0,
  input wire logic ready_strobe_pin,
  input wire logic [1:0] input_clock_mode,
  input wire logic [1:0] output_transfer_mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // level that rises on the capture edge of the active mode
  logic cap;
  assign cap = (input_clock_mode[0] ^ input_clock_mode[1]) ? !sclk : sclk;
  property p_legacy_low;
    !cs_n && output_transfer_mode == 2'h0 |-> !ready_strobe_pin;
  endproperty
  a_legacy_low: assert property (p_legacy_low) else $error("strobe high in frame");
  property p_reset_mode;
    $rose(hresetn) |-> input_clock_mode == 2'h0 && output_transfer_mode == 2'h0;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode after reset");
  property p_mode_apply;
    $changed(input_clock_mode) |-> cs_n && $past(cs_n);
  endproperty
  a_mode_apply: assert property (p_mode_apply) else $error("mode changed in frame");
  property p_out_stable;
    !cs_n && !$past(cs_n) |-> $stable(output_transfer_mode);
  endproperty
  a_out_stable: assert property (p_out_stable) else $error("output mode moved");
  property p_idle_fall;
    $fell(cs_n) |-> sclk == input_clock_mode[1];
  endproperty
  a_idle_fall: assert property (p_idle_fall) else $error("idle level at start");
  property p_idle_rise;
    $rose(cs_n) |-> $past(sclk) == input_clock_mode[1];
  endproperty
  a_idle_rise: assert property (p_idle_rise) else $error("idle level at end");
  property p_cap_stable;
    $rose(cap) && !cs_n && output_transfer_mode == 2'h0 |-> $stable(serial_out_lane0);
  endproperty
  a_cap_stable: assert property (p_cap_stable) else $error("data moved at capture");
  property p_strobe_src;
    $changed(ready_strobe_pin) |-> output_transfer_mode != 2'h0;
  endproperty
  a_strobe_src: assert property (p_strobe_src) else $error("strobe in legacy");
endmodule

// *** verif/tb.sv ***
// self-checking bench: host end drives device end over the link
`timescale 1ns/10ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rx, e;
  logic [1:0] icm, otm;
  logic [13:0] conv = 14'h2A5C; // conversion input levels
  logic [1:0] sup = 2'h2;
  logic [1:0] inp = 2'h1;
  logic [3:0] rng = 4'h9;
  int err_total = 0;
  int compares = 0;
  ash_link_if link ();
  ash_dev_end #(.STROBE_HALF(2)) u_ash_dev_end (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .link(link.dev), .conv_result(conv), .supply_alarm(sup), .input_alarm(inp),
    .input_range(rng), .input_clock_mode(icm), .output_transfer_mode(otm));
  ash_host_end #(.SCLK_HALF(4)) u_ash_host_end (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link(link.host));
  ash_chk u_ash_chk (.hclk(hclk), .hresetn(hresetn), .cs_n(link.cs_n), .sclk(link.sclk),
    .serial_out_lane0(link.serial_out_lane0), .ready_strobe_pin(link.ready_strobe_pin),
    .input_clock_mode(icm), .output_transfer_mode(otm));
  always #2.5 hclk = ~hclk;
  // one single-word bus transfer; read data lands in rx
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rx = hrdata;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // set host config, send one command frame, wait until idle, fetch received bits
  task frame(input logic [31:0] cfg, input logic [31:0] cmd);
    ahb(1'b1, ash_pkg::H_CFG, cfg);
    ahb(1'b1, ash_pkg::H_CMD, cmd);
    rx = 32'h1;
    for (int i = 0; i < 500 && rx[0] !== 1'b0; i++) ahb(1'b0, ash_pkg::H_STAT, 32'h0);
    ahb(1'b0, ash_pkg::H_RX, 32'h0);
  endtask
  function automatic logic [31:0] cf(input logic [5:0] n, input logic [4:0] f);
    return {18'h0, n, 3'h0, f};
  endfunction
  function automatic logic [31:0] wr(input logic [7:0] a, input logic [15:0] d);
    return {ash_pkg::OP_WRITE, 2'h0, 1'b0, a, d};
  endfunction
  // expected output word for a set of append enables
  function automatic logic [31:0] pack(input logic [4:0] en);
    logic [31:0] w;
    int p;
    w = {conv, 18'h0};
    p = 18;
    if (en[4]) begin p = p - 4; w[p+:4] = 4'h5; end
    if (en[3]) begin p = p - 2; w[p+:2] = sup; end
    if (en[2]) begin p = p - 2; w[p+:2] = inp; end
    if (en[1]) begin p = p - 4; w[p+:4] = rng; end
    if (en[0]) begin p = p - 2; w[p+:2] = {^conv, ^w[17:0]}; end
    return w;
  endfunction
  task results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    results();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, ash_pkg::H_CFG, 32'h0);
    chk("cfg", ash_pkg::HC_CFG_RST, rx);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rx);
    frame(cf(32, 0), wr(8'h02, 16'h0005));
    frame(cf(32, 0), wr(8'h10, 16'h001F));
    frame(cf(32, 0), 32'h0);
    chk("all flags", pack(5'h1F), rx);
    frame(cf(32, 0), wr(8'h10, 16'h000B));
    frame(cf(32, 0), 32'h0);
    chk("some flags", pack(5'h0B), rx);
    frame(cf(32, 0), {ash_pkg::OP_READ_HW, 2'h0, 1'b0, 8'h10, 16'h0});
    frame(cf(32, 0), 32'h0);
    chk("hword", 32'h000B0000, rx);
    e = pack(5'h0B);
    frame(cf(8, 0), wr(8'h10, 16'h0));
    chk("short", {24'h0, e[31:24]}, rx);
    frame(cf(32, 0), 32'h0);
    chk("after short", e, rx);
    for (int m = 1; m < 4; m++) begin
      frame(cf(32, 0), wr(8'h08, 16'(m)));
      conv <= conv + 14'h0111;
      frame(cf(32, 5'(m)), 32'h0);
      chk("mode word", pack(5'h0B), rx);
      frame(cf(32, 5'(m)), wr(8'h08, 16'h0));
    end
    frame(cf(32, 0), wr(8'h0C, 16'h000C));
    frame(cf(16, 5'h04), 32'h0);
    chk("dual", pack(5'h0B), rx);
    frame(cf(32, 0), wr(8'h0C, 16'h000D));
    frame(cf(16, 5'h0C), 32'h0);
    chk("src ext", pack(5'h0B), rx);
    frame(cf(32, 0), wr(8'h0C, 16'h004D));
    frame(cf(16, 5'h1C), 32'h0);
    chk("src int", pack(5'h0B), rx);
    results();
  end
endmodule
